// *** verilog/ioem_cfg.svh ***
// Offsets, field positions, reset values of the isoch interrupt block
// Assumes byte addresses on an 8-bit register port with 32-bit data
`ifndef IOEM_CFG_SVH
`define IOEM_CFG_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define IOEM_OFS_MAIN_EV_SET 8'h80
`define IOEM_OFS_MAIN_EV_CLR 8'h84
`define IOEM_OFS_MAIN_MK_SET 8'h88
`define IOEM_OFS_MAIN_MK_CLR 8'h8C
`define IOEM_OFS_TX_EV_SET   8'h90
`define IOEM_OFS_TX_EV_CLR   8'h94
`define IOEM_OFS_TX_MK_SET   8'h98
`define IOEM_OFS_TX_MK_CLR   8'h9C
`define IOEM_OFS_RX_EV_SET   8'hA0
`define IOEM_OFS_RX_EV_CLR   8'hA4
`define IOEM_OFS_RX_MK_SET   8'hA8
`define IOEM_OFS_RX_MK_CLR   8'hAC

// ----------------------------------------
// Field positions and bit groups
// ----------------------------------------
`define IOEM_BIT_TX_SUM      6
`define IOEM_BIT_RX_SUM      7
`define IOEM_BIT_GLOBAL      31
`define IOEM_MAIN_EV_BITS    32'h0001833F
`define IOEM_MAIN_SRC_BITS   32'h000183FF
`define IOEM_MAIN_MK_BITS    32'h800183FF
`define IOEM_RSVD_LO         10
`define IOEM_RSVD_HI         14

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IOEM_RST_WORD        32'h00000000
`define IOEM_RST_CHAN        1'b0

`endif

// *** verilog/ioem_pkg.sv ***
// Types shared by the isoch interrupt block
// Assumes the constants header is included where numbers are needed
`default_nettype none
package ioem_pkg;
  typedef logic [31:0] ioem_word_type;
  typedef logic [7:0]  ioem_addr_type;
endpackage
`default_nettype wire

// *** verilog/ioem_bank_if.sv ***
// Carrier between the top and one per-channel event/mask bank
// Assumes the top drives the controls and pulses on the bank clock
`default_nettype none
interface ioem_bank_if #(parameter int N = 8);
  logic [N-1:0] wdata;
  logic [N-1:0] pulse;
  logic [N-1:0] evt_q;
  logic [N-1:0] mask_q;
  logic         set_ev;
  logic         clr_ev;
  logic         set_mk;
  logic         clr_mk;
  modport bank (input wdata, pulse, set_ev, clr_ev, set_mk, clr_mk,
                output evt_q, mask_q);
  modport ctl  (output wdata, pulse, set_ev, clr_ev, set_mk, clr_mk,
                input evt_q, mask_q);
endinterface
`default_nettype wire

// *** verilog/ioem_chan_bank.sv ***
// Per-channel sticky event bits and mask bits with set/clear writes
// Assumes pulses come from logic on clk_sys; no synchroniser needed
`default_nettype none
`include "ioem_cfg.svh"
module ioem_chan_bank #(
  parameter int N = 8
) (
  input  wire logic  clk_sys,
  input  wire logic  rstn,
  ioem_bank_if.bank  bus
);
  logic [N-1:0] evt_ff;
  logic [N-1:0] mask_ff;
  logic [N-1:0] prev_ff;
  logic [N-1:0] rise;
  logic [N-1:0] nxt_evt;
  logic [N-1:0] nxt_mask;

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  // Rising edge of a done pulse; set beats clear in the same cycle
  assign rise     = bus.pulse & ~prev_ff;
  assign nxt_evt  = (evt_ff & ~({N{bus.clr_ev}} & bus.wdata)) | rise
                  | ({N{bus.set_ev}} & bus.wdata);
  assign nxt_mask = (mask_ff & ~({N{bus.clr_mk}} & bus.wdata))
                  | ({N{bus.set_mk}} & bus.wdata);
  assign bus.evt_q  = evt_ff;
  assign bus.mask_q = mask_ff;

  // Storage
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      evt_ff  <= {N{`IOEM_RST_CHAN}};
      mask_ff <= {N{`IOEM_RST_CHAN}};
      prev_ff <= {N{`IOEM_RST_CHAN}};
    end else begin
      evt_ff  <= nxt_evt;
      mask_ff <= nxt_mask;
      prev_ff <= bus.pulse;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_EDGE_SETS: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rise != '0) |=> ((evt_ff & $past(rise)) == $past(rise)))
    else $error("channel edge did not set its event bit");
  AST_ONLY_W1C: assert property (@(posedge clk_sys) disable iff (!rstn)
    ($past(evt_ff) & ~evt_ff) != '0 |-> $past(bus.clr_ev))
    else $error("event bit cleared without a clear write");
  AST_SET_WRITE: assert property (@(posedge clk_sys) disable iff (!rstn)
    bus.set_ev |=> ((evt_ff & $past(bus.wdata)) == $past(bus.wdata)))
    else $error("set write did not set event bits");
  AST_MASK_CLR: assert property (@(posedge clk_sys) disable iff (!rstn)
    bus.clr_mk && (bus.wdata != '0) |=> ((mask_ff & $past(bus.wdata)) == '0))
    else $error("mask clear write left bits set");
endmodule
`default_nettype wire

// *** verilog/ioem_isoch_irq.sv ***
// Top of the isoch interrupt event and mask block
// Assumes a single-cycle register port on clk_sys and done pulses
// from context logic on the same clock
`default_nettype none
`include "ioem_cfg.svh"

// Summary of operation
// - Source interrupts only when event and mask set
// - Main mask bits 14..10 read zero
// - Transmit context completion raises its channel event
// - Receive context completion raises its channel event
// - Transmit event set by edge or write-one
// - Receive event set by edge or write-one
// - Channel events clear only by write-one clear
// - Transmit clear address reads event AND mask
// - Receive clear address reads event AND mask
// - Transmit event eight bits, upper bits zero
// - Receive event four bits, upper bits zero
// - Transmit mask aligned, read at both addresses
// - Receive mask aligned, read at both addresses
// - Pending transmit event shows in bit six
// - Pending receive event shows in bit seven
// - Global gate low blocks the interrupt output
module ioem_isoch_irq #(
  parameter int TX_N = 8,
  parameter int RX_N = 4
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rstn,
  input  wire ioem_pkg::ioem_addr_type reg_addr,
  input  wire ioem_pkg::ioem_word_type reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output      ioem_pkg::ioem_word_type reg_rdata,
  input  wire logic [TX_N-1:0]       tx_done_pulse,
  input  wire logic [RX_N-1:0]       rx_done_pulse,
  input  wire logic [16:0]           main_evt_pulse,
  output logic                       irq_out
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  ioem_pkg::ioem_word_type main_evt_ff;
  ioem_pkg::ioem_word_type main_mask_ff;
  ioem_pkg::ioem_word_type rdata_ff;
  logic                    irq_ff;

  ioem_pkg::ioem_word_type nxt_main_evt;
  ioem_pkg::ioem_word_type nxt_main_mask;
  ioem_pkg::ioem_word_type nxt_rdata;
  logic                    nxt_irq;

  ioem_pkg::ioem_word_type main_set;
  ioem_pkg::ioem_word_type main_clr;
  ioem_pkg::ioem_word_type main_view;
  ioem_pkg::ioem_word_type main_enabled;
  ioem_pkg::ioem_word_type tx_ev_word;
  ioem_pkg::ioem_word_type tx_mk_word;
  ioem_pkg::ioem_word_type rx_ev_word;
  ioem_pkg::ioem_word_type rx_mk_word;

  logic tx_sum;
  logic rx_sum;

  // Bus decode strobes
  logic wr_main_ev_set;
  logic wr_main_ev_clr;
  logic wr_main_mk_set;
  logic wr_main_mk_clr;
  logic rd_main_ev_set;
  logic rd_main_ev_clr;
  logic rd_main_mk;
  logic rd_tx_ev_set;
  logic rd_tx_ev_clr;
  logic rd_tx_mk;
  logic rd_rx_ev_set;
  logic rd_rx_ev_clr;
  logic rd_rx_mk;

  ioem_bank_if #(.N(TX_N)) tx_if ();
  ioem_bank_if #(.N(RX_N)) rx_if ();

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Write strobes for the main registers
  assign wr_main_ev_set = reg_wr && (reg_addr == `IOEM_OFS_MAIN_EV_SET);
  assign wr_main_ev_clr = reg_wr && (reg_addr == `IOEM_OFS_MAIN_EV_CLR);
  assign wr_main_mk_set = reg_wr && (reg_addr == `IOEM_OFS_MAIN_MK_SET);
  assign wr_main_mk_clr = reg_wr && (reg_addr == `IOEM_OFS_MAIN_MK_CLR);

  // Read selects; mask reads answer at both addresses
  assign rd_main_ev_set = reg_rd && (reg_addr == `IOEM_OFS_MAIN_EV_SET);
  assign rd_main_ev_clr = reg_rd && (reg_addr == `IOEM_OFS_MAIN_EV_CLR);
  assign rd_main_mk     = reg_rd && ((reg_addr == `IOEM_OFS_MAIN_MK_SET)
                                  || (reg_addr == `IOEM_OFS_MAIN_MK_CLR));
  assign rd_tx_ev_set   = reg_rd && (reg_addr == `IOEM_OFS_TX_EV_SET);
  assign rd_tx_ev_clr   = reg_rd && (reg_addr == `IOEM_OFS_TX_EV_CLR);
  assign rd_tx_mk       = reg_rd && ((reg_addr == `IOEM_OFS_TX_MK_SET)
                                  || (reg_addr == `IOEM_OFS_TX_MK_CLR));
  assign rd_rx_ev_set   = reg_rd && (reg_addr == `IOEM_OFS_RX_EV_SET);
  assign rd_rx_ev_clr   = reg_rd && (reg_addr == `IOEM_OFS_RX_EV_CLR);
  assign rd_rx_mk       = reg_rd && ((reg_addr == `IOEM_OFS_RX_MK_SET)
                                  || (reg_addr == `IOEM_OFS_RX_MK_CLR));

  // ----------------------------------------
  // Channel banks
  // ----------------------------------------
  // Transmit bank: completion pulses of the output contexts
  assign tx_if.wdata  = reg_wdata[TX_N-1:0];
  assign tx_if.pulse  = tx_done_pulse;
  assign tx_if.set_ev = reg_wr && (reg_addr == `IOEM_OFS_TX_EV_SET);
  assign tx_if.clr_ev = reg_wr && (reg_addr == `IOEM_OFS_TX_EV_CLR);
  assign tx_if.set_mk = reg_wr && (reg_addr == `IOEM_OFS_TX_MK_SET);
  assign tx_if.clr_mk = reg_wr && (reg_addr == `IOEM_OFS_TX_MK_CLR);

  // Receive bank: completion pulses of the input contexts
  assign rx_if.wdata  = reg_wdata[RX_N-1:0];
  assign rx_if.pulse  = rx_done_pulse;
  assign rx_if.set_ev = reg_wr && (reg_addr == `IOEM_OFS_RX_EV_SET);
  assign rx_if.clr_ev = reg_wr && (reg_addr == `IOEM_OFS_RX_EV_CLR);
  assign rx_if.set_mk = reg_wr && (reg_addr == `IOEM_OFS_RX_MK_SET);
  assign rx_if.clr_mk = reg_wr && (reg_addr == `IOEM_OFS_RX_MK_CLR);

  ioem_chan_bank #(.N(TX_N)) u_tx_bank (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .bus     (tx_if.bank)
  );

  ioem_chan_bank #(.N(RX_N)) u_rx_bank (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .bus     (rx_if.bank)
  );

  // Zero-extended views; upper bits read as zero
  assign tx_ev_word = {{(32-TX_N){1'b0}}, tx_if.evt_q};
  assign tx_mk_word = {{(32-TX_N){1'b0}}, tx_if.mask_q};
  assign rx_ev_word = {{(32-RX_N){1'b0}}, rx_if.evt_q};
  assign rx_mk_word = {{(32-RX_N){1'b0}}, rx_if.mask_q};

  // ----------------------------------------
  // Summaries and main event register
  // ----------------------------------------
  // Summary bits follow the masked channel events
  assign tx_sum = |(tx_if.evt_q & tx_if.mask_q);
  assign rx_sum = |(rx_if.evt_q & rx_if.mask_q);

  // Main sticky bits: pulses and W1S set, W1C or clear-read clear
  assign main_set = {15'h0000, main_evt_pulse}
                  | ({32{wr_main_ev_set}} & reg_wdata);
  assign main_clr = ({32{wr_main_ev_clr}} & reg_wdata)
                  | {32{rd_main_ev_clr}};
  assign nxt_main_evt = ((main_evt_ff & ~main_clr) | main_set)
                      & `IOEM_MAIN_EV_BITS;

  // Main view with the two summaries placed in their bits
  always_comb begin
    main_view = main_evt_ff;
    main_view[`IOEM_BIT_TX_SUM] = tx_sum;
    main_view[`IOEM_BIT_RX_SUM] = rx_sum;
  end

  // Main mask: W1S and W1C, reserved bits never stored
  assign nxt_main_mask = ((main_mask_ff
                        & ~({32{wr_main_mk_clr}} & reg_wdata))
                        | ({32{wr_main_mk_set}} & reg_wdata))
                        & `IOEM_MAIN_MK_BITS;

  // ----------------------------------------
  // Interrupt output
  // ----------------------------------------
  // Each source needs both its event and its mask bit
  assign main_enabled = main_view & main_mask_ff
                      & `IOEM_MAIN_SRC_BITS;
  assign nxt_irq = main_mask_ff[`IOEM_BIT_GLOBAL]
                 && (|main_enabled);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // One-hot read selection; unmapped reads return zero
  assign nxt_rdata =
      rd_main_ev_set ? main_view :
      rd_main_ev_clr ? main_view & main_mask_ff :
      rd_main_mk     ? main_mask_ff :
      rd_tx_ev_set   ? tx_ev_word :
      rd_tx_ev_clr   ? tx_ev_word & tx_mk_word :
      rd_tx_mk       ? tx_mk_word :
      rd_rx_ev_set   ? rx_ev_word :
      rd_rx_ev_clr   ? rx_ev_word & rx_mk_word :
      rd_rx_mk       ? rx_mk_word :
                       `IOEM_RST_WORD;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Main event and mask storage
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      main_evt_ff  <= `IOEM_RST_WORD;
      main_mask_ff <= `IOEM_RST_WORD;
    end else begin
      main_evt_ff  <= nxt_main_evt;
      main_mask_ff <= nxt_main_mask;
    end
  end

  // Output flops: read data one cycle after the strobe, interrupt
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= `IOEM_RST_WORD;
      irq_ff   <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      irq_ff   <= nxt_irq;
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq_out   = irq_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Reserved mask field reads back as zero
  AST_RSVD_ZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_main_mk |=> (reg_rdata[`IOEM_RSVD_HI:`IOEM_RSVD_LO] == 5'h00))
    else $error("reserved mask bits read nonzero");

  // Transmit clear address returns the masked events
  AST_TX_MASKED: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_tx_ev_clr |=> (reg_rdata == ($past(tx_ev_word) & $past(tx_mk_word))))
    else $error("transmit clear read not event AND mask");

  // Receive set address returns raw events, upper bits zero
  AST_RX_RAW: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_rx_ev_set |=> (reg_rdata == $past(rx_ev_word))
                     && (reg_rdata[31:4] == 28'h0000000))
    else $error("receive set read wrong");

  // Transmit event upper bits always zero
  AST_TX_HI: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_tx_ev_set |=> (reg_rdata[31:8] == 24'h000000))
    else $error("transmit event upper bits nonzero");

  // Transmit mask readable at both addresses
  AST_TX_MASK_RD: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_tx_mk |=> (reg_rdata == $past(tx_mk_word)))
    else $error("transmit mask read wrong");

  // Receive mask readable at both addresses
  AST_RX_MASK_RD: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_rx_mk |=> (reg_rdata == $past(rx_mk_word)))
    else $error("receive mask read wrong");

  // Summary bit six tracks masked transmit events
  AST_TX_SUM: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_main_ev_set |=> (reg_rdata[`IOEM_BIT_TX_SUM] == $past(tx_sum)))
    else $error("transmit summary wrong");

  // Summary bit seven tracks masked receive events
  AST_RX_SUM: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_main_ev_set |=> (reg_rdata[`IOEM_BIT_RX_SUM] == $past(rx_sum)))
    else $error("receive summary wrong");

  // Gate low keeps the output low one cycle later
  AST_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
    !main_mask_ff[`IOEM_BIT_GLOBAL] |=> !irq_out)
    else $error("interrupt raised with gate off");

  // Enabled source with gate high raises the output next cycle
  AST_IRQ_RAISE: assert property (@(posedge clk_sys) disable iff (!rstn)
    main_mask_ff[`IOEM_BIT_GLOBAL] && (main_enabled != '0) |=> irq_out)
    else $error("interrupt not raised");

  // No enabled source keeps the output low
  AST_IRQ_QUIET: assert property (@(posedge clk_sys) disable iff (!rstn)
    (main_enabled == '0) |=> !irq_out)
    else $error("interrupt without an enabled source");

  // Transmit set address returns the raw events
  AST_TX_RAW: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_tx_ev_set |=> (reg_rdata == $past(tx_ev_word)))
    else $error("transmit set read not raw events");

  // Receive clear address returns the masked events
  AST_RX_MASKED: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_rx_ev_clr |=> (reg_rdata == ($past(rx_ev_word) & $past(rx_mk_word))))
    else $error("receive clear read not event AND mask");

  // Main set address returns stored bits with live summaries
  AST_MAIN_RAW_RD: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_main_ev_set |=> (reg_rdata == $past(main_view)))
    else $error("main event read wrong");

  // Main clear address returns the enabled events
  AST_MAIN_CLR_RD: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_main_ev_clr |=> (reg_rdata == ($past(main_view) & $past(main_mask_ff))))
    else $error("main clear read not event AND mask");

  // Main mask readable at both addresses
  AST_MAIN_MK_RD: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_main_mk |=> (reg_rdata == $past(main_mask_ff)))
    else $error("main mask read wrong");

  // Write-one set of main events lands on the defined bits
  AST_MAIN_SET_WR: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_main_ev_set |=> ((main_evt_ff & $past(reg_wdata) & `IOEM_MAIN_EV_BITS)
                       == ($past(reg_wdata) & `IOEM_MAIN_EV_BITS)))
    else $error("main event set write lost");

  // Write-one set of the main mask lands on the defined bits
  AST_MASK_SET_WR: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_main_mk_set |=> ((main_mask_ff & $past(reg_wdata) & `IOEM_MAIN_MK_BITS)
                       == ($past(reg_wdata) & `IOEM_MAIN_MK_BITS)))
    else $error("main mask set write lost");

  // Write-one clear of the main mask drops the named bits
  AST_MASK_CLR_WR: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_main_mk_clr |=> ((main_mask_ff & $past(reg_wdata)) == 32'h00000000))
    else $error("main mask clear write left bits set");

  // A main source pulse sets its sticky bit
  AST_MAIN_PULSE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (main_evt_pulse != '0) |=> ((main_evt_ff & {15'h0000, $past(main_evt_pulse)} & `IOEM_MAIN_EV_BITS)
                               == ({15'h0000, $past(main_evt_pulse)} & `IOEM_MAIN_EV_BITS)))
    else $error("main source pulse did not set its bit");

  // Enabled transmit summary with gate high raises the output
  AST_TX_SUM_IRQ: assert property (@(posedge clk_sys) disable iff (!rstn)
    tx_sum && main_mask_ff[`IOEM_BIT_TX_SUM] && main_mask_ff[`IOEM_BIT_GLOBAL] |=> irq_out)
    else $error("transmit summary did not raise interrupt");

  // Enabled receive summary with gate high raises the output
  AST_RX_SUM_IRQ: assert property (@(posedge clk_sys) disable iff (!rstn)
    rx_sum && main_mask_ff[`IOEM_BIT_RX_SUM] && main_mask_ff[`IOEM_BIT_GLOBAL] |=> irq_out)
    else $error("receive summary did not raise interrupt");

endmodule
`default_nettype wire

// *** verif/ioem_isoch_irq_tb.sv ***
// Self-checking bench of the isoch interrupt event and mask block
// Assumes the constants header and the package are compiled before this file
`default_nettype none
`include "ioem_cfg.svh"

`define IOEM_CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module ioem_isoch_irq_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // Signals and reference state
  // ----------------------------------------
  logic                    clk_sys;
  logic                    rstn;
  ioem_pkg::ioem_addr_type reg_addr;
  ioem_pkg::ioem_word_type reg_wdata;
  logic                    reg_wr;
  logic                    reg_rd;
  ioem_pkg::ioem_word_type reg_rdata;
  logic [7:0]              tx_done_pulse;
  logic [3:0]              rx_done_pulse;
  logic [16:0]             main_evt_pulse;
  logic                    irq_out;
  int                      fail_count;
  int                      n_compared;
  int                      cycles;
  int                      op;
  logic [7:0]              tx_ev;
  logic [7:0]              tx_mk;
  logic [3:0]              rx_ev;
  logic [3:0]              rx_mk;
  ioem_pkg::ioem_word_type m_ev;
  ioem_pkg::ioem_word_type m_mk;
  ioem_pkg::ioem_addr_type addrs [13];

  ioem_isoch_irq #(.TX_N(8), .RX_N(4)) ioem_isoch_irq_inst (
    .clk_sys        (clk_sys),
    .rstn           (rstn),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_rdata      (reg_rdata),
    .tx_done_pulse  (tx_done_pulse),
    .rx_done_pulse  (rx_done_pulse),
    .main_evt_pulse (main_evt_pulse),
    .irq_out        (irq_out)
  );

  // ----------------------------------------
  // Expected values
  // ----------------------------------------
  // Main event view: stored bits plus live channel summaries
  function automatic ioem_pkg::ioem_word_type main_view();
    main_view = m_ev & `IOEM_MAIN_EV_BITS;
    main_view[`IOEM_BIT_TX_SUM] = |(tx_ev & tx_mk);
    main_view[`IOEM_BIT_RX_SUM] = |(rx_ev & rx_mk);
  endfunction

  // Interrupt level: enabled sources gated by the global bit
  function automatic logic exp_irq();
    exp_irq = m_mk[`IOEM_BIT_GLOBAL] & (|(main_view() & m_mk & `IOEM_MAIN_SRC_BITS));
  endfunction

  // Read data expected at each address
  function automatic ioem_pkg::ioem_word_type exp_rd(input ioem_pkg::ioem_addr_type a);
    case (a)
      `IOEM_OFS_MAIN_EV_SET: exp_rd = main_view();
      `IOEM_OFS_MAIN_EV_CLR: exp_rd = main_view() & m_mk;
      `IOEM_OFS_MAIN_MK_SET, `IOEM_OFS_MAIN_MK_CLR: exp_rd = m_mk;
      `IOEM_OFS_TX_EV_SET: exp_rd = {24'h000000, tx_ev};
      `IOEM_OFS_TX_EV_CLR: exp_rd = {24'h000000, tx_ev & tx_mk};
      `IOEM_OFS_TX_MK_SET, `IOEM_OFS_TX_MK_CLR: exp_rd = {24'h000000, tx_mk};
      `IOEM_OFS_RX_EV_SET: exp_rd = {28'h0000000, rx_ev};
      `IOEM_OFS_RX_EV_CLR: exp_rd = {28'h0000000, rx_ev & rx_mk};
      `IOEM_OFS_RX_MK_SET, `IOEM_OFS_RX_MK_CLR: exp_rd = {28'h0000000, rx_mk};
      default: exp_rd = 32'h00000000;
    endcase
  endfunction

  // ----------------------------------------
  // Bus and pulse tasks
  // ----------------------------------------
  // One-cycle write, then the reference state follows it
  task automatic do_wr(input ioem_pkg::ioem_addr_type a, input ioem_pkg::ioem_word_type d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    case (a)
      `IOEM_OFS_MAIN_EV_SET: m_ev = m_ev | (d & `IOEM_MAIN_EV_BITS);
      `IOEM_OFS_MAIN_EV_CLR: m_ev = m_ev & ~d;
      `IOEM_OFS_MAIN_MK_SET: m_mk = m_mk | (d & `IOEM_MAIN_MK_BITS);
      `IOEM_OFS_MAIN_MK_CLR: m_mk = m_mk & ~d;
      `IOEM_OFS_TX_EV_SET: tx_ev = tx_ev | d[7:0];
      `IOEM_OFS_TX_EV_CLR: tx_ev = tx_ev & ~d[7:0];
      `IOEM_OFS_TX_MK_SET: tx_mk = tx_mk | d[7:0];
      `IOEM_OFS_TX_MK_CLR: tx_mk = tx_mk & ~d[7:0];
      `IOEM_OFS_RX_EV_SET: rx_ev = rx_ev | d[3:0];
      `IOEM_OFS_RX_EV_CLR: rx_ev = rx_ev & ~d[3:0];
      `IOEM_OFS_RX_MK_SET: rx_mk = rx_mk | d[3:0];
      `IOEM_OFS_RX_MK_CLR: rx_mk = rx_mk & ~d[3:0];
      default: ;
    endcase
  endtask

  // One-cycle read; data checked in the cycle after the strobe
  task automatic rd_chk(input ioem_pkg::ioem_addr_type a);
    ioem_pkg::ioem_word_type exp;
    exp = exp_rd(a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `IOEM_CHK(reg_rdata, exp)
    if (a == `IOEM_OFS_MAIN_EV_CLR) begin
      m_ev = 32'h00000000;
    end
  endtask

  // Completion pulses lasting one cycle
  task automatic pulse(input logic [7:0] t, input logic [3:0] r, input logic [16:0] m);
    @(posedge clk_sys);
    tx_done_pulse <= t;
    rx_done_pulse <= r;
    main_evt_pulse <= m;
    @(posedge clk_sys);
    tx_done_pulse <= 8'h00;
    rx_done_pulse <= 4'h0;
    main_evt_pulse <= 17'h00000;
    tx_ev = tx_ev | t;
    rx_ev = rx_ev | r;
    m_ev = m_ev | ({15'h0000, m} & `IOEM_MAIN_EV_BITS);
  endtask

  // Interrupt level once the registered output has settled
  task automatic irq_chk();
    repeat (2) @(posedge clk_sys);
    #1;
    `IOEM_CHK(irq_out, exp_irq())
  endtask

  // Counts, verdict and end of run
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock and hang limit
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Cuts the run short if a task never returns
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    tx_done_pulse = 8'h00;
    rx_done_pulse = 4'h0;
    main_evt_pulse = 17'h00000;
    {tx_ev, tx_mk, rx_ev, rx_mk, m_ev, m_mk} = '0;
    fail_count = 0;
    n_compared = 0;
    cycles = 0;
    addrs = '{8'h80, 8'h84, 8'h88, 8'h8C, 8'h90, 8'h94, 8'h98, 8'h9C, 8'hA0, 8'hA4, 8'hA8, 8'hAC, 8'hB0};
    void'($urandom(32'h536A));
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    foreach (addrs[i]) rd_chk(addrs[i]);
    $display("test reset_values done");
    do_wr(`IOEM_OFS_MAIN_MK_SET, 32'hFFFFFFFF);
    rd_chk(`IOEM_OFS_MAIN_MK_SET);
    rd_chk(`IOEM_OFS_MAIN_MK_CLR);
    do_wr(8'hB0, 32'hFFFFFFFF);
    rd_chk(8'hB0);
    $display("test reserved_bits done");
    do_wr(`IOEM_OFS_TX_MK_SET, 32'h00000008);
    @(posedge clk_sys);
    tx_done_pulse <= 8'h08;
    tx_ev[3] = 1'b1;
    repeat (2) @(posedge clk_sys);
    do_wr(`IOEM_OFS_TX_EV_CLR, 32'h00000008);
    rd_chk(`IOEM_OFS_TX_EV_SET);
    irq_chk();
    @(posedge clk_sys);
    tx_done_pulse <= 8'h00;
    // Edge and clear write in one cycle: the set wins
    @(posedge clk_sys);
    tx_done_pulse <= 8'h01;
    reg_wr <= 1'b1;
    reg_addr <= `IOEM_OFS_TX_EV_CLR;
    reg_wdata <= 32'h00000001;
    @(posedge clk_sys);
    tx_done_pulse <= 8'h00;
    reg_wr <= 1'b0;
    tx_ev[0] = 1'b1;
    rd_chk(`IOEM_OFS_TX_EV_SET);
    $display("test held_pulse done");
    pulse(8'h20, 4'h0, 17'h00000);
    irq_chk();
    do_wr(`IOEM_OFS_TX_MK_SET, 32'h00000020);
    irq_chk();
    rd_chk(`IOEM_OFS_TX_EV_SET);
    rd_chk(`IOEM_OFS_TX_EV_SET);
    rd_chk(`IOEM_OFS_MAIN_EV_SET);
    do_wr(`IOEM_OFS_MAIN_MK_CLR, 32'h00000040);
    irq_chk();
    do_wr(`IOEM_OFS_MAIN_MK_SET, 32'h00000040);
    do_wr(`IOEM_OFS_MAIN_MK_CLR, 32'h80000000);
    irq_chk();
    do_wr(`IOEM_OFS_MAIN_MK_SET, 32'h80000000);
    pulse(8'h00, 4'h2, 17'h00000);
    do_wr(`IOEM_OFS_RX_MK_SET, 32'h00000002);
    rd_chk(`IOEM_OFS_RX_EV_CLR);
    rd_chk(`IOEM_OFS_MAIN_EV_SET);
    do_wr(`IOEM_OFS_TX_EV_CLR, 32'hFFFFFFFF);
    do_wr(`IOEM_OFS_RX_EV_CLR, 32'hFFFFFFFF);
    irq_chk();
    $display("test summaries done");
    pulse(8'h00, 4'h0, 17'h1FFFF);
    irq_chk();
    rd_chk(`IOEM_OFS_MAIN_EV_SET);
    rd_chk(`IOEM_OFS_MAIN_EV_CLR);
    irq_chk();
    do_wr(`IOEM_OFS_MAIN_EV_SET, 32'hFFFFFFFF);
    rd_chk(`IOEM_OFS_MAIN_EV_SET);
    do_wr(`IOEM_OFS_MAIN_EV_CLR, 32'h0000FFFF);
    rd_chk(`IOEM_OFS_MAIN_EV_SET);
    irq_chk();
    $display("test main_sources done");
    for (int k = 0; k < 300; k++) begin
      op = int'($urandom_range(0, 3));
      case (op)
        0: do_wr(addrs[$urandom_range(0, 12)], $urandom());
        1: rd_chk(addrs[$urandom_range(0, 12)]);
        2: pulse(8'($urandom()), 4'h0, 17'h00000);
        default: pulse(8'h00, 4'($urandom()), 17'($urandom()));
      endcase
      irq_chk();
    end
    $display("test random_traffic done");
    summarize();
  end
endmodule

`default_nettype wire
